// file: logic/fasm_unit.v
// float add, subtract, multiply and divide sequencer beside a host data path
// assumes the host answers each word fetch with rd_valid and takes results on store_valid
`include "fasm_regs.vh"

module fasm_unit (
  input  wire        core_clk,
  input  wire        resetn,
  input  wire        start,
  input  wire [1:0]  op,
  output wire        rd_req,
  output wire [1:0]  rd_sel,
  input  wire        rd_valid,
  input  wire [15:0] rd_data,
  output wire        store_valid,
  output wire [15:0] res_hi,
  output wire [15:0] res_lo,
  output wire [3:0]  cc,
  output wire        psw_load,
  output wire        done,
  output wire        busy
);

  // ****************************************
  // states
  // ****************************************
  localparam S_IDLE   = 14'h0001;
  localparam S_FETCH  = 14'h0002;
  localparam S_UNPACK = 14'h0004;
  localparam S_DECODE = 14'h0008;
  localparam S_CMPL   = 14'h0010;
  localparam S_SWAP   = 14'h0020;
  localparam S_ALIGN  = 14'h0040;
  localparam S_SUM    = 14'h0080;
  localparam S_FIX    = 14'h0100;
  localparam S_MUL    = 14'h0200;
  localparam S_DIV    = 14'h0400;
  localparam S_LAUNCH = 14'h0800;
  localparam S_NORM   = 14'h1000;
  localparam S_STORE  = 14'h2000;

  // ****************************************
  // registers
  // ****************************************
  reg [13:0] st_r;
  reg [1:0]  op_r;
  reg [1:0]  sel_r;
  reg [15:0] hi_r;
  reg [15:0] lo_r;
  reg [15:0] scratch_r;
  reg        bs_r;
  reg [7:0]  be_r;
  reg [23:0] bm_r;
  reg        as_r;
  reg [7:0]  ae_r;
  reg [23:0] am_r;
  reg [27:0] xb_r;
  reg [27:0] xa_r;
  reg [9:0]  eb_r;
  reg [9:0]  ea_r;
  reg [27:0] sum_r;
  reg [9:0]  cnt_r;
  reg [25:0] pp_r;
  reg [25:0] mid_shift_reg_r;
  reg        n_sign_r;
  reg [9:0]  n_exp_r;
  reg [23:0] n_mant_r;
  reg        n_grd_r;
  reg [15:0] res_hi_r;
  reg [15:0] res_lo_r;
  reg [3:0]  cc_r;
  reg        wr_en_r;
  reg        store_valid_r;
  reg        psw_load_r;
  reg        done_r;

  // ****************************************
  // datapath terms
  // ****************************************
  wire [23:0] unp_mant_w = {1'b1, hi_r[`FASM_MHI_HI:0], lo_r};
  wire        unp_zero_w = (scratch_r[7:0] == 8'h00);
  wire [9:0]  ediff_w    = eb_r - ea_r;
  wire [9:0]  ediff_n_w  = ea_r - eb_r;
  wire [27:0] mag_w      = sum_r[27] ? (~sum_r + 28'h0000001) : sum_r;
  wire        multiplier_lsb = mid_shift_reg_r[0];
  wire [24:0] psum_w     = {1'b0, pp_r[23:0]} + (multiplier_lsb ? {1'b0, am_r} : 25'h0000000);
  wire        ge_w       = pp_r >= {2'b00, am_r};
  wire [25:0] rdif_w     = pp_r - {2'b00, am_r};
  wire [25:0] rsel_w     = ge_w ? rdif_w : pp_r;
  wire [9:0]  mexp_w     = {2'b00, ae_r} + {2'b00, be_r} - `FASM_EXP_BIAS;
  wire [9:0]  dexp_w     = {2'b00, be_r} - {2'b00, ae_r} + `FASM_EXP_BIAS;
  wire        launch_w   = (st_r == S_LAUNCH);
  wire        nd_w;
  wire [15:0] n_hi_w;
  wire [15:0] n_lo_w;
  wire [3:0]  n_cc_w;
  wire        n_ok_w;

  assign rd_req      = (st_r == S_FETCH);
  assign rd_sel      = sel_r;
  assign store_valid = store_valid_r;
  assign res_hi      = res_hi_r;
  assign res_lo      = res_lo_r;
  assign cc          = cc_r;
  assign psw_load    = psw_load_r;
  assign done        = done_r;
  assign busy        = (st_r != S_IDLE);

  // ****************************************
  // shared normalize, round and pack stage
  // ****************************************
  fasm_norm u_norm (
    .core_clk (core_clk),
    .resetn   (resetn),
    .start    (launch_w),
    .sign_in  (n_sign_r),
    .exp_in   (n_exp_r),
    .mant_in  (n_mant_r),
    .grd_in   (n_grd_r),
    .done     (nd_w),
    .res_hi   (n_hi_w),
    .res_lo   (n_lo_w),
    .cc       (n_cc_w),
    .ok       (n_ok_w)
  );

  // ****************************************
  // sequencer
  // ****************************************
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= S_IDLE;
      op_r <= `FASM_OP_ADD;
      sel_r <= `FASM_SEL_BHI;
      hi_r <= 16'h0000;
      lo_r <= 16'h0000;
      scratch_r <= 16'h0000;
      bs_r <= 1'b0;
      be_r <= 8'h00;
      bm_r <= 24'h000000;
      as_r <= 1'b0;
      ae_r <= 8'h00;
      am_r <= 24'h000000;
      xb_r <= 28'h0000000;
      xa_r <= 28'h0000000;
      eb_r <= 10'h000;
      ea_r <= 10'h000;
      sum_r <= 28'h0000000;
      cnt_r <= 10'h000;
      pp_r <= 26'h0000000;
      mid_shift_reg_r <= 26'h0000000;
      n_sign_r <= 1'b0;
      n_exp_r <= 10'h000;
      n_mant_r <= 24'h000000;
      n_grd_r <= 1'b0;
      res_hi_r <= 16'h0000;
      res_lo_r <= 16'h0000;
      cc_r <= 4'h0;
      wr_en_r <= 1'b0;
      store_valid_r <= 1'b0;
      psw_load_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      store_valid_r <= 1'b0;
      psw_load_r <= 1'b0;
      done_r <= 1'b0;
      case (st_r)
        S_IDLE: begin
          if (start) begin
            op_r <= op;
            sel_r <= `FASM_SEL_BHI;
            st_r <= S_FETCH;
          end
        end
        S_FETCH: begin
          if (rd_valid) begin
            if (sel_r == `FASM_SEL_BHI || sel_r == `FASM_SEL_AHI) begin
              hi_r <= rd_data;
              scratch_r <= {8'h00, rd_data[`FASM_EXP_HI:`FASM_EXP_LO]};
              sel_r <= sel_r + 2'h1;
            end else begin
              lo_r <= rd_data;
              st_r <= S_UNPACK;
            end
          end
        end
        S_UNPACK: begin
          if (sel_r == `FASM_SEL_BLO) begin
            bs_r <= unp_zero_w ? 1'b0 : hi_r[`FASM_SIGN_BIT];
            be_r <= scratch_r[7:0];
            bm_r <= unp_zero_w ? 24'h000000 : unp_mant_w;
            sel_r <= `FASM_SEL_AHI;
            st_r <= S_FETCH;
          end else begin
            as_r <= unp_zero_w ? 1'b0 : hi_r[`FASM_SIGN_BIT];
            ae_r <= scratch_r[7:0];
            am_r <= unp_zero_w ? 24'h000000 : unp_mant_w;
            st_r <= S_DECODE;
          end
        end
        S_DECODE: begin
          case (op_r)
            `FASM_OP_ADD: st_r <= S_CMPL;
            `FASM_OP_SUB: begin
              as_r <= ~as_r;
              st_r <= S_CMPL;
            end
            `FASM_OP_MUL: begin
              if (am_r == 24'h000000 || bm_r == 24'h000000) begin
                res_hi_r <= 16'h0000;
                res_lo_r <= 16'h0000;
                cc_r <= `FASM_CC_ZERO;
                wr_en_r <= 1'b1;
                st_r <= S_STORE;
              end else begin
                n_sign_r <= as_r ^ bs_r;
                n_exp_r <= mexp_w;
                cnt_r <= `FASM_MUL_STEPS;
                pp_r <= 26'h0000000;
                mid_shift_reg_r <= {2'b00, bm_r};
                st_r <= S_MUL;
              end
            end
            default: begin
              if (am_r == 24'h000000) begin
                cc_r <= `FASM_CC_UNF;
                wr_en_r <= 1'b0;
                st_r <= S_STORE;
              end else if (bm_r == 24'h000000) begin
                res_hi_r <= 16'h0000;
                res_lo_r <= 16'h0000;
                cc_r <= `FASM_CC_ZERO;
                wr_en_r <= 1'b1;
                st_r <= S_STORE;
              end else begin
                n_sign_r <= as_r ^ bs_r;
                n_exp_r <= dexp_w;
                cnt_r <= `FASM_DIV_STEPS;
                pp_r <= {2'b00, bm_r};
                mid_shift_reg_r <= 26'h0000000;
                st_r <= S_DIV;
              end
            end
          endcase
        end
        S_CMPL: begin
          xb_r <= bs_r ? (28'h0000000 - {2'b00, bm_r, 2'b00}) : {2'b00, bm_r, 2'b00};
          xa_r <= as_r ? (28'h0000000 - {2'b00, am_r, 2'b00}) : {2'b00, am_r, 2'b00};
          eb_r <= {2'b00, be_r};
          ea_r <= {2'b00, ae_r};
          st_r <= S_SWAP;
        end
        S_SWAP: begin
          if (ediff_w[9]) begin
            xb_r <= xa_r;
            xa_r <= xb_r;
            eb_r <= ea_r;
            ea_r <= eb_r;
            cnt_r <= ediff_n_w;
          end else begin
            cnt_r <= ediff_w;
          end
          st_r <= S_ALIGN;
        end
        S_ALIGN: begin
          if (cnt_r > `FASM_ALIGN_MAX) begin
            sum_r <= xb_r;
            st_r <= S_FIX;
          end else if (cnt_r == 10'h000) begin
            st_r <= S_SUM;
          end else begin
            xa_r <= {xa_r[27], xa_r[27:1]};
            ea_r <= ea_r + `FASM_EXP_ONE;
            cnt_r <= cnt_r - 10'h001;
          end
        end
        S_SUM: begin
          sum_r <= xb_r + xa_r;
          st_r <= S_FIX;
        end
        S_FIX: begin
          n_sign_r <= sum_r[27];
          if (mag_w[26]) begin
            n_mant_r <= mag_w[26:3];
            n_grd_r <= mag_w[2];
            n_exp_r <= eb_r + `FASM_EXP_ONE;
          end else begin
            n_mant_r <= mag_w[25:2];
            n_grd_r <= mag_w[1];
            n_exp_r <= eb_r;
          end
          st_r <= S_LAUNCH;
        end
        S_MUL: begin
          if (cnt_r == 10'h000) begin
            n_mant_r <= pp_r[23:0];
            n_grd_r <= mid_shift_reg_r[25];
            st_r <= S_LAUNCH;
          end else begin
            pp_r <= {2'b00, psum_w[24:1]};
            mid_shift_reg_r <= {psum_w[0], mid_shift_reg_r[25:1]};
            cnt_r <= cnt_r - 10'h001;
          end
        end
        S_DIV: begin
          if (cnt_r == 10'h000) begin
            if (mid_shift_reg_r[25]) begin
              n_mant_r <= mid_shift_reg_r[25:2];
              n_grd_r <= mid_shift_reg_r[1];
              n_exp_r <= n_exp_r + `FASM_EXP_ONE;
            end else begin
              n_mant_r <= mid_shift_reg_r[24:1];
              n_grd_r <= mid_shift_reg_r[0];
            end
            st_r <= S_LAUNCH;
          end else begin
            pp_r <= {rsel_w[24:0], 1'b0};
            mid_shift_reg_r <= {mid_shift_reg_r[24:0], ge_w};
            cnt_r <= cnt_r - 10'h001;
          end
        end
        S_LAUNCH: st_r <= S_NORM;
        S_NORM: begin
          if (nd_w) begin
            res_hi_r <= n_hi_w;
            res_lo_r <= n_lo_w;
            cc_r <= n_cc_w;
            wr_en_r <= n_ok_w;
            st_r <= S_STORE;
          end
        end
        S_STORE: begin
          store_valid_r <= wr_en_r;
          psw_load_r <= 1'b1;
          done_r <= 1'b1;
          st_r <= S_IDLE;
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

endmodule // fasm_unit

// file: shared/fasm_regs.vh
// constants for the float add/sub/mul/div sequencer
// assumes 32-bit operands: sign, 8-bit excess-128 exponent, 23-bit stored fraction
`ifndef FASM_REGS_VH
`define FASM_REGS_VH
// operation codes
`define FASM_OP_ADD    2'h0
`define FASM_OP_SUB    2'h1
`define FASM_OP_MUL    2'h2
`define FASM_OP_DIV    2'h3
// operand word select on the fetch port
`define FASM_SEL_BHI   2'h0
`define FASM_SEL_BLO   2'h1
`define FASM_SEL_AHI   2'h2
`define FASM_SEL_ALO   2'h3
// high word fields
`define FASM_SIGN_BIT  15
`define FASM_EXP_HI    14
`define FASM_EXP_LO    7
`define FASM_MHI_HI    6
// exponent arithmetic
`define FASM_EXP_BIAS  10'h080
`define FASM_EXP_MAX   10'h0FF
`define FASM_EXP_MIN   10'h001
`define FASM_EXP_ONE   10'h001
// counts
`define FASM_ALIGN_MAX 10'h018
`define FASM_MUL_STEPS 10'h018
`define FASM_DIV_STEPS 10'h01A
// mantissa with hidden one
`define FASM_HIDDEN    24'h800000
// condition code bits and patterns
`define FASM_CC_N      3
`define FASM_CC_Z      2
`define FASM_CC_V      1
`define FASM_CC_C      0
`define FASM_CC_ZERO   4'h4
`define FASM_CC_UNF    4'h1
`endif

// file: logic/fasm_norm.v
// normalize, round and pack stage of the float sequencer
// assumes one start pulse per result and an unsigned 24-bit mantissa with one extra bit
`include "fasm_regs.vh"

module fasm_norm (
  input  wire        core_clk,
  input  wire        resetn,
  input  wire        start,
  input  wire        sign_in,
  input  wire [9:0]  exp_in,
  input  wire [23:0] mant_in,
  input  wire        grd_in,
  output wire        done,
  output wire [15:0] res_hi,
  output wire [15:0] res_lo,
  output wire [3:0]  cc,
  output wire        ok
);

  // ****************************************
  // state and working registers
  // ****************************************
  localparam N_IDLE  = 4'h1;
  localparam N_SHIFT = 4'h2;
  localparam N_ROUND = 4'h4;
  localparam N_PACK  = 4'h8;

  reg [3:0]  st_r;
  reg        s_r;
  reg [9:0]  e_r;
  reg [23:0] m_r;
  reg        g_r;
  reg        z_r;
  reg        done_r;
  reg [15:0] hi_r;
  reg [15:0] lo_r;
  reg [3:0]  cc_r;
  reg        ok_r;

  wire [24:0] rsum_w = {1'b0, m_r} + {24'h000000, g_r};
  wire        ovf_w  = !z_r && ($signed(e_r) > $signed(`FASM_EXP_MAX));
  wire        unf_w  = !z_r && ($signed(e_r) < $signed(`FASM_EXP_MIN));

  assign done   = done_r;
  assign res_hi = hi_r;
  assign res_lo = lo_r;
  assign cc     = cc_r;
  assign ok     = ok_r;

  // ****************************************
  // sequence
  // ****************************************
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_r   <= N_IDLE;
      s_r    <= 1'b0;
      e_r    <= 10'h000;
      m_r    <= 24'h000000;
      g_r    <= 1'b0;
      z_r    <= 1'b0;
      done_r <= 1'b0;
      hi_r   <= 16'h0000;
      lo_r   <= 16'h0000;
      cc_r   <= 4'h0;
      ok_r   <= 1'b0;
    end else begin
      done_r <= 1'b0;
      case (st_r)
        N_IDLE: begin
          if (start) begin
            s_r  <= sign_in;
            e_r  <= exp_in;
            m_r  <= mant_in;
            g_r  <= grd_in;
            z_r  <= 1'b0;
            st_r <= N_SHIFT;
          end
        end
        N_SHIFT: begin
          if (m_r == 24'h000000 && !g_r) begin
            z_r  <= 1'b1;
            st_r <= N_PACK;
          end else if (m_r[23]) begin
            st_r <= N_ROUND;
          end else begin
            m_r <= {m_r[22:0], g_r};
            g_r <= 1'b0;
            e_r <= e_r - `FASM_EXP_ONE;
          end
        end
        N_ROUND: begin
          if (rsum_w[24]) begin
            m_r <= `FASM_HIDDEN;
            e_r <= e_r + `FASM_EXP_ONE;
          end else begin
            m_r <= rsum_w[23:0];
          end
          st_r <= N_PACK;
        end
        N_PACK: begin
          if (z_r) begin
            hi_r <= 16'h0000;
            lo_r <= 16'h0000;
            cc_r <= `FASM_CC_ZERO;
          end else begin
            hi_r <= {s_r, e_r[7:0], m_r[22:16]};
            lo_r <= m_r[15:0];
            cc_r <= {s_r, 1'b0, ovf_w, unf_w};
          end
          ok_r   <= !ovf_w && !unf_w;
          done_r <= 1'b1;
          st_r   <= N_IDLE;
        end
        default: st_r <= N_IDLE;
      endcase
    end
  end

endmodule // fasm_norm

// file: dv/fasm_unit_asserts.sv
// checker for the float sequencer, bound to its top ports
// assumes one clock domain and an async active-low reset
`include "fasm_regs.vh"

// ****************************************
// port checker
// ****************************************
module fasm_unit_chk (
  input logic        core_clk,
  input logic        resetn,
  input logic        start,
  input logic        rd_req,
  input logic [1:0]  rd_sel,
  input logic        rd_valid,
  input logic        store_valid,
  input logic [15:0] res_hi,
  input logic [3:0]  cc,
  input logic        psw_load,
  input logic        done,
  input logic        busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  AST_BHI_BLO: assert property (rd_req && rd_valid && rd_sel == `FASM_SEL_BHI |=>
    rd_req && rd_sel == `FASM_SEL_BLO) else $error("high B not followed by low B");
  AST_BLO_AHI: assert property (rd_req && rd_valid && rd_sel == `FASM_SEL_BLO |=>
    !rd_req ##1 (rd_req && rd_sel == `FASM_SEL_AHI)) else $error("A fetch not after B");
  AST_AHI_ALO: assert property (rd_req && rd_valid && rd_sel == `FASM_SEL_AHI |=>
    rd_req && rd_sel == `FASM_SEL_ALO) else $error("high A not followed by low A");
  AST_REQ_HOLD: assert property (rd_req && !rd_valid |=> rd_req && $stable(rd_sel))
    else $error("fetch request dropped before answer");
  AST_IDLE_NOREQ: assert property (!busy |-> !rd_req)
    else $error("fetch while idle");
  AST_START_BUSY: assert property (start && !busy |=> busy)
    else $error("start not taken");
  AST_DONE_BOUND: assert property (start && !busy |-> ##[1:300] done)
    else $error("operation did not finish");
  AST_DONE_ONE: assert property (done |=> !done)
    else $error("done longer than one cycle");
  AST_DONE_PSW: assert property (done |-> psw_load)
    else $error("codes not loaded at finish");
  AST_STORE_DONE: assert property (store_valid |-> done)
    else $error("store outside finish cycle");
  AST_OVF_NOSTORE: assert property (done && (cc[1] || cc[0]) |-> !store_valid)
    else $error("store despite range error");
  AST_ZERO_CC: assert property (store_valid && res_hi[14:7] == 8'h00 |-> cc[2])
    else $error("zero result without zero code");
endmodule // fasm_unit_chk

bind fasm_unit fasm_unit_chk i_chk (
  .core_clk    (core_clk),
  .resetn      (resetn),
  .start       (start),
  .rd_req      (rd_req),
  .rd_sel      (rd_sel),
  .rd_valid    (rd_valid),
  .store_valid (store_valid),
  .res_hi      (res_hi),
  .cc          (cc),
  .psw_load    (psw_load),
  .done        (done),
  .busy        (busy)
);

// file: dv/fasm_host_model.sv
// host data path model answering operand word fetches
// assumes the bench presets the four words before start

// ****************************************
// fetch responder
// ****************************************
module fasm_host_model (
  input  logic        core_clk,
  input  logic        resetn,
  input  logic        rd_req,
  input  logic [1:0]  rd_sel,
  input  logic        slow,
  input  logic [63:0] words,
  output logic        rd_valid,
  output logic [15:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] last_w;

  initial begin
    rd_valid = 1'b0;
    rd_data  = 16'h0000;
    last_w   = 16'h0000;
  end

  // answers only a standing request; otherwise shows the inverse of the last word
  always @(negedge core_clk) begin
    if (resetn && rd_req && (!slow || $urandom_range(1, 0) == 1)) begin
      rd_valid <= 1'b1;
      rd_data  <= 16'(words >> (48 - 16 * rd_sel));
      last_w   <= 16'(words >> (48 - 16 * rd_sel));
    end else begin
      rd_valid <= 1'b0;
      rd_data  <= ~last_w;
    end
  end
endmodule // fasm_host_model

// file: dv/fasm_unit_test.sv
// self-checking bench for the float sequencer
// assumes the host model and checker files are compiled beside it
`include "fasm_regs.vh"

// ****************************************
// bench top
// ****************************************
module fasm_unit_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk;
  logic        resetn;
  logic        start;
  logic [1:0]  op;
  logic        rd_req;
  logic [1:0]  rd_sel;
  logic        rd_valid;
  logic [15:0] rd_data;
  logic        store_valid;
  logic [15:0] res_hi;
  logic [15:0] res_lo;
  logic [3:0]  cc;
  logic        psw_load;
  logic        done;
  logic        busy;
  logic        slow;
  logic [63:0] words;
  logic [31:0] exp_q[$];
  int          n_fail;
  int          num_checks;
  int          a;
  int          b;
  int          k;
  int          r;

  fasm_unit i_dut (.core_clk(core_clk), .resetn(resetn), .start(start), .op(op),
    .rd_req(rd_req), .rd_sel(rd_sel), .rd_valid(rd_valid), .rd_data(rd_data),
    .store_valid(store_valid), .res_hi(res_hi), .res_lo(res_lo), .cc(cc),
    .psw_load(psw_load), .done(done), .busy(busy));
  fasm_host_model i_host (.core_clk(core_clk), .resetn(resetn), .rd_req(rd_req),
    .rd_sel(rd_sel), .slow(slow), .words(words), .rd_valid(rd_valid), .rd_data(rd_data));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // packs an integer as sign, excess-128 exponent, fraction without hidden one
  function automatic logic [31:0] mk(input int v);
    int m;
    int p;
    logic [23:0] mt;
    if (v == 0) return 32'h00000000;
    m = v < 0 ? -v : v;
    p = $clog2(m + 1) - 1;
    mt = 24'(m) << (23 - p);
    return {v < 0, 8'(129 + p), mt[22:0]};
  endfunction

  function automatic logic [3:0] ccv(input int v);
    return {v < 0, v == 0, 2'b00};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic run(input logic [1:0] o, input logic [31:0] bw, input logic [31:0] aw,
                     input logic [31:0] er, input logic [3:0] ecm, input logic [3:0] ecc,
                     input logic es);
    int n;
    logic st;
    words = {bw, aw};
    exp_q.push_back(er);
    @(negedge core_clk);
    while (busy !== 1'b0) @(negedge core_clk);
    start = 1'b1;
    op = o;
    @(negedge core_clk);
    start = 1'b0;
    @(negedge core_clk);
    start = 1'b1;
    op = 2'($urandom);
    @(negedge core_clk);
    start = 1'b0;
    n = 0;
    st = 1'b0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
      if (store_valid === 1'b1) st = 1'b1;
    end while (done !== 1'b1 && n < 400);
    chk(done, 1'b1);
    chk(psw_load, 1'b1);
    chk(st, es);
    if (es) chk({res_hi, res_lo}, exp_q[0]);
    void'(exp_q.pop_front());
    chk(cc & ecm, ecc);
  endtask

  task report_and_stop;
    $display("checks=%0d fails=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #160000;
    n_fail++;
    report_and_stop;
  end

  initial begin
    resetn = 1'b0;
    start = 1'b0;
    op = 2'h0;
    slow = 1'b0;
    words = 64'h0;
    n_fail = 0;
    num_checks = 0;
    void'($urandom(32'hAA10));
    repeat (4) @(negedge core_clk);
    chk({busy, rd_req, done}, 3'h0);
    resetn = 1'b1;
    // op codes add, subtract, multiply, divide are 0..3
    for (int g = 0; g < 4; g++) begin
      for (int i = 0; i < 6; i++) begin
        slow = i[0];
        b = int'($urandom_range(4000)) - 2000;
        a = int'($urandom_range(4000)) - 2000;
        r = g == 0 ? b + a : g == 1 ? b - a : b * a;
        if (g == 3) begin
          if (a == 0) a = 7;
          k = b / 4;
          b = a * k;
          r = k;
        end
        run(2'(g), mk(b), mk(a), mk(r), 4'hF, ccv(r), 1'b1);
      end
      $display("test op %0d done", g);
    end
    run(`FASM_OP_SUB, mk(5), mk(5), 32'h0, 4'hF, 4'h4, 1'b1);
    run(`FASM_OP_ADD, mk(1 << 23), mk(1), mk((1 << 23) + 1), 4'hF, 4'h0, 1'b1);
    run(`FASM_OP_ADD, mk(1 << 25), mk(1), mk(1 << 25), 4'hF, 4'h0, 1'b1);
    run(`FASM_OP_ADD, mk(-1), mk(1 << 25), mk(1 << 25), 4'hF, 4'h0, 1'b1);
    run(`FASM_OP_ADD, 32'h807FFFFF, mk(5), mk(5), 4'hF, 4'h0, 1'b1);
    run(`FASM_OP_MUL, mk(9), mk(0), 32'h0, 4'hF, 4'h4, 1'b1);
    run(`FASM_OP_DIV, mk(0), mk(3), 32'h0, 4'hF, 4'h4, 1'b1);
    run(`FASM_OP_DIV, mk(7), mk(0), 32'h0, 4'hF, 4'h1, 1'b0);
    run(`FASM_OP_MUL, 32'h7F800000, 32'h7F800000, 32'h0, 4'h2, 4'h2, 1'b0);
    run(`FASM_OP_MUL, 32'h00800000, 32'h00800000, 32'h0, 4'h1, 4'h1, 1'b0);
    $display("test special cases done");
    report_and_stop;
  end
endmodule // fasm_unit_test
